// [rtl/dci_pkg.sv]
`default_nettype none
package dci_pkg;

   // Transport overhead geometry of one STS-9 frame, walked one bit per overhead clock.
   localparam int BITS_PER_BYTE = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [4:0] TOH_BYTE_LAST = 5'h1a;
   localparam logic [3:0] TOH_ROW_LAST = 4'h8;

   // Rows and interleaved byte columns that carry the data channel bytes.
   localparam logic [3:0] SECTION_ROW = 4'h2;
   localparam logic [3:0] LINE_ROW_FIRST = 4'h5;
   localparam logic [3:0] LINE_ROW_LAST = 4'h7;
   localparam logic [4:0] CHAN_BYTE_A = 5'h00;
   localparam logic [4:0] CHAN_BYTE_B = 5'h09;
   localparam logic [4:0] CHAN_BYTE_C = 5'h12;

   // Byte sent when the controller has not delivered a fresh byte in time.
   localparam logic [7:0] IDLE_FILL = 8'h7e;

   typedef enum logic [1:0] {
      DCI_SLOT_NONE,
      DCI_SLOT_SECTION,
      DCI_SLOT_LINE
   } dci_slot_t;

   typedef struct packed {
      logic valid;
      dci_slot_t slot;
      logic [7:0] data;
   } dci_byte_t;

endpackage
`default_nettype wire

// [rtl/dci_chan_deser.sv]
`timescale 1ns/1ps
`default_nettype none
module dci_chan_deser #(
   parameter int BYTE_W = 8
) (
   // Link side.
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic sample,
   input wire logic serial_in,
   // System side.
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic take,
   output logic [BYTE_W-1:0] byte_out,
   output logic fresh
);

   localparam int CNT_W = $clog2(BYTE_W);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BYTE_W - 1);

   logic [BYTE_W-1:0] shift;
   logic [BYTE_W-1:0] hold;
   logic [CNT_W-1:0] cnt;
   logic tgl;
   logic [2:0] tgl_sync;

   generate
      if (BYTE_W < 2) begin : g_chk
         $error("dci_chan_deser needs BYTE_W of at least 2");
      end
   endgenerate

   // Bits are captured on the falling edge, half a period after the far end launched them.
   always_ff @(negedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         shift <= '0;
         hold <= '0;
         cnt <= '0;
         tgl <= 1'b0;
      end else if (sample) begin
         shift <= {shift[BYTE_W-2:0], serial_in};
         if (cnt == CNT_LAST) begin
            hold <= {shift[BYTE_W-2:0], serial_in};
            tgl <= ~tgl;
            cnt <= '0;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // The held byte stays still for a whole byte of overhead clocks, far longer than the toggle takes to cross.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tgl_sync <= '0;
      end else begin
         tgl_sync <= {tgl_sync[1:0], tgl};
      end
   end

   // A new byte arriving in the same cycle it is consumed keeps fresh set.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         byte_out <= '0;
         fresh <= 1'b0;
      end else if (tgl_sync[2] != tgl_sync[1]) begin
         byte_out <= hold;
         fresh <= 1'b1;
      end else if (take) begin
         fresh <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [rtl/dci_tx_dcc_insert.sv]
`timescale 1ns/1ps
`default_nettype none
module dci_tx_dcc_insert
   import dci_pkg::*;
#(
   parameter int BYTE_W = 8
) (
   // System clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Overhead port clock source and its forwarded copy.
   input wire logic link_clk,
   output logic overhead_port_clock,
   // Section channel port.
   output logic section_chan_bit_request,
   input wire logic section_chan_serial_in,
   // Line channel port.
   output logic line_chan_bit_request,
   input wire logic line_chan_serial_in,
   // Outbound byte stream.
   input wire dci_byte_t stream_in,
   output dci_byte_t stream_out
);

   logic [1:0] link_rst_sync;
   logic link_rst_n;
   logic [2:0] bit_cnt;
   logic [4:0] byte_cnt;
   logic [3:0] row_cnt;
   logic [2:0] next_bit_cnt;
   logic [4:0] next_byte_cnt;
   logic [3:0] next_row_cnt;
   logic byte_wrap;
   logic row_wrap;
   logic chan_byte;
   logic sec_slot;
   logic line_slot;
   logic sec_pend;
   logic line_pend;
   logic sec_take;
   logic line_take;
   logic [BYTE_W-1:0] sec_byte;
   logic [BYTE_W-1:0] line_byte;
   logic sec_fresh;
   logic line_fresh;
   dci_byte_t next_stream_out;

   // The slot map is fixed by the package, so a bad geometry is refused before it can misplace bytes.
   generate
      if (BYTE_W != BITS_PER_BYTE) begin : g_chk
         $error("dci_tx_dcc_insert carries whole octets only");
      end
      if (SECTION_ROW >= LINE_ROW_FIRST) begin : g_rows
         $error("dci_tx_dcc_insert needs the section row ahead of the line rows");
      end
      if ((LINE_ROW_LAST > TOH_ROW_LAST) || (CHAN_BYTE_C > TOH_BYTE_LAST)) begin : g_geom
         $error("dci_tx_dcc_insert channel slots lie outside the overhead");
      end
   endgenerate

   // The device sources the overhead clock, so the far end sees the same edges the link logic uses.
   assign overhead_port_clock = link_clk;

   // Reset release is retimed so the link counters all leave reset on one edge.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_rst_sync <= 2'b00;
      end else begin
         link_rst_sync <= {link_rst_sync[0], 1'b1};
      end
   end
   assign link_rst_n = link_rst_sync[1];

   // Walk the overhead bit by bit: bit, interleaved byte, row.
   // Alignment comes from reset alone, as the port carries no frame marker for the far end.
   assign byte_wrap = (bit_cnt == BIT_LAST);
   assign row_wrap = byte_wrap && (byte_cnt == TOH_BYTE_LAST);

   always_comb begin
      next_bit_cnt = bit_cnt + 3'h1;
      next_byte_cnt = byte_cnt;
      next_row_cnt = row_cnt;
      if (byte_wrap) begin
         next_bit_cnt = '0;
         next_byte_cnt = byte_cnt + 5'h01;
      end
      if (row_wrap) begin
         next_byte_cnt = '0;
         next_row_cnt = row_cnt + 4'h1;
         if (row_cnt == TOH_ROW_LAST) begin
            next_row_cnt = '0;
         end
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt <= '0;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         byte_cnt <= '0;
      end else begin
         byte_cnt <= next_byte_cnt;
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         row_cnt <= '0;
      end else begin
         row_cnt <= next_row_cnt;
      end
   end

   // Only the first tributary's columns carry the channel bytes.
   assign chan_byte = (byte_cnt == CHAN_BYTE_A) ||
      (byte_cnt == CHAN_BYTE_B) ||
      (byte_cnt == CHAN_BYTE_C);
   assign sec_slot = chan_byte && (row_cnt == SECTION_ROW);
   assign line_slot = chan_byte &&
      (row_cnt >= LINE_ROW_FIRST) && (row_cnt <= LINE_ROW_LAST);

   // One request period per bit slot, so request-high periods per frame equal channel bits carried.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         section_chan_bit_request <= 1'b0;
      end else begin
         section_chan_bit_request <= sec_slot;
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         line_chan_bit_request <= 1'b0;
      end else begin
         line_chan_bit_request <= line_slot;
      end
   end

   // The far end answers a request on the next rising edge; the bit is taken mid-period after it.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sec_pend <= 1'b0;
      end else begin
         sec_pend <= section_chan_bit_request;
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         line_pend <= 1'b0;
      end else begin
         line_pend <= line_chan_bit_request;
      end
   end

   // Falling-edge capture and byte assembly, one instance per channel.
   dci_chan_deser #(
      .BYTE_W(BYTE_W)
   ) u_section (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .sample(sec_pend),
      .serial_in(section_chan_serial_in),
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .take(sec_take),
      .byte_out(sec_byte),
      .fresh(sec_fresh)
   );

   // The line channel has its own copy of the capture path, so both channels see identical timing.
   dci_chan_deser #(
      .BYTE_W(BYTE_W)
   ) u_line (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .sample(line_pend),
      .serial_in(line_chan_serial_in),
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .take(line_take),
      .byte_out(line_byte),
      .fresh(line_fresh)
   );

   // Each channel slot in the stream consumes at most one captured byte per cycle.
   assign sec_take = stream_in.valid && (stream_in.slot == DCI_SLOT_SECTION);
   assign line_take = stream_in.valid && (stream_in.slot == DCI_SLOT_LINE);

   // A missing byte is replaced by idle fill rather than repeating stale data into the channel.
   always_comb begin
      next_stream_out = stream_in;
      if (sec_take) begin
         next_stream_out.data = sec_fresh ? sec_byte : IDLE_FILL;
      end else if (line_take) begin
         next_stream_out.data = line_fresh ? line_byte : IDLE_FILL;
      end
   end

   // Registered so every byte sees one cycle of latency whether or not it carries a channel slot.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stream_out <= '0;
      end else begin
         stream_out <= next_stream_out;
      end
   end

endmodule
`default_nettype wire

// [tb/dci_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module dci_far_end #(
   parameter logic [7:0] PATTERN = 8'hc6
) (
   // Overhead port.
   input wire logic port_clk,
   input wire logic bit_request,
   output logic serial_out
);
   logic [2:0] idx = 3'h7;
   initial serial_out = 1'b0;
   // Unrequested slots toggle so a stale bit can never pass for a good one.
   always @(posedge port_clk) begin
      if (bit_request) begin
         serial_out <= PATTERN[idx];
         idx <= idx - 3'h1;
      end else begin
         serial_out <= ~serial_out;
      end
   end
endmodule
`default_nettype wire

// [tb/dci_tx_dcc_insert_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dci_tx_dcc_insert_properties
   import dci_pkg::*;
(
   // Clocks and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic link_clk,
   // Watched signals.
   input wire logic section_chan_bit_request,
   input wire logic line_chan_bit_request,
   input wire dci_byte_t stream_in,
   input wire dci_byte_t stream_out
);
   sequence s_sec_byte;
      section_chan_bit_request [*8] ##1 !section_chan_bit_request;
   endsequence
   sequence s_line_byte;
      line_chan_bit_request [*8] ##1 !line_chan_bit_request;
   endsequence
   AST_SEC_BYTE: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(section_chan_bit_request) |-> s_sec_byte) else $error("section request length wrong");
   AST_LINE_BYTE: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(line_chan_bit_request) |-> s_line_byte) else $error("line request length wrong");
   AST_SEC_GAP: assert property (@(posedge link_clk) disable iff (!rst_n)
      $fell(section_chan_bit_request) |-> !section_chan_bit_request [*8]) else $error("section gap short");
   AST_EXCL: assert property (@(posedge link_clk) disable iff (!rst_n)
      !(section_chan_bit_request && line_chan_bit_request)) else $error("both requests high");
   AST_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!stream_in.valid || stream_in.slot == DCI_SLOT_NONE) |=> stream_out == $past(stream_in))
      else $error("plain byte altered");
   AST_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stream_in.valid && stream_in.slot != DCI_SLOT_NONE) |=>
      stream_out.valid && stream_out.slot == $past(stream_in.slot)) else $error("slot byte lost");
endmodule
bind dci_tx_dcc_insert dci_tx_dcc_insert_properties i_props (.clk_sys, .rst_n, .link_clk,
   .section_chan_bit_request, .line_chan_bit_request, .stream_in, .stream_out);
`default_nettype wire

// [tb/tb_tx_dcc_serial_insert_ports.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_tx_dcc_serial_insert_ports
   import dci_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, link_clk = 1'b0;
   logic section_chan_bit_request, line_chan_bit_request, section_chan_serial_in, line_chan_serial_in;
   logic overhead_port_clock;
   dci_byte_t stream_in = '0;
   dci_byte_t stream_out;
   int num_errors = 0, samples_checked = 0, sec_cnt = 0, line_cnt = 0, clk_cnt = 0;
   dci_tx_dcc_insert i_dut (.clk_sys, .rst_n, .link_clk, .overhead_port_clock,
      .section_chan_bit_request, .section_chan_serial_in, .line_chan_bit_request,
      .line_chan_serial_in, .stream_in, .stream_out);
   dci_far_end #(.PATTERN(8'hc6)) i_sec (.port_clk(overhead_port_clock), .bit_request(section_chan_bit_request),
      .serial_out(section_chan_serial_in));
   dci_far_end #(.PATTERN(8'h2d)) i_line (.port_clk(overhead_port_clock), .bit_request(line_chan_bit_request),
      .serial_out(line_chan_serial_in));
   initial forever #4 clk_sys = ~clk_sys;
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end
   always @(negedge link_clk) begin
      sec_cnt += int'(section_chan_bit_request);
      line_cnt += int'(line_chan_bit_request);
   end
   always @(negedge overhead_port_clock) clk_cnt++;
   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input dci_slot_t s, input logic [7:0] d, input logic [7:0] exp);
      @(negedge clk_sys) stream_in <= '{1'b1, s, d};
      @(negedge clk_sys) check(stream_out, {1'b1, s, exp});
   endtask
   task automatic test_idle();
      xfer(DCI_SLOT_NONE, 8'h55, 8'h55);
      xfer(DCI_SLOT_SECTION, 8'h00, IDLE_FILL);
      xfer(DCI_SLOT_LINE, 8'h00, IDLE_FILL);
      $display("test_idle done");
   endtask
   task automatic test_section();
      @(negedge section_chan_bit_request);
      repeat (30) @(negedge clk_sys);
      xfer(DCI_SLOT_SECTION, 8'h00, 8'hc6);
      xfer(DCI_SLOT_SECTION, 8'h00, IDLE_FILL);
      $display("test_section done");
   endtask
   task automatic test_line();
      @(negedge line_chan_bit_request);
      repeat (30) @(negedge clk_sys);
      xfer(DCI_SLOT_LINE, 8'h11, 8'h2d);
      xfer(DCI_SLOT_LINE, 8'h11, IDLE_FILL);
      $display("test_line done");
   endtask
   task automatic test_frame();
      int s0, l0, c0;
      @(posedge link_clk);
      s0 = sec_cnt;
      l0 = line_cnt;
      c0 = clk_cnt;
      repeat (12'h798) @(posedge link_clk);
      check(11'(sec_cnt - s0), 11'h018);
      check(11'(line_cnt - l0), 11'h048);
      check(11'(clk_cnt - c0), 11'h798);
      $display("test_frame done");
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge link_clk);
      @(negedge clk_sys) rst_n <= 1'b1;
      test_idle();
      test_section();
      test_line();
      test_frame();
      report_and_stop();
   end
endmodule
`default_nettype wire
